// ---- rtl/typec_port_control.sv ----
// Type-C port controller digital face: role, attach, status pins.
// Assumes CC front end levels arrive unsynchronised; serial block is on clk_in.
`timescale 1ns/1ps
`include "typec_regs.svh"
module typec_port_control (
	input  wire logic                         clk_in,
	input  wire logic                         reset_in,
	input  wire logic                         chip_enable_n_in,
	input  wire logic                         port_strap_high_in,
	input  wire logic                         port_strap_low_in,
	input  wire logic                         addr_strap_high_in,
	input  wire logic                         addr_strap_low_in,
	input  wire logic                         cc_sink_seen_in,
	input  wire logic                         cc_source_seen_in,
	input  wire logic                         cc_audio_seen_in,
	input  wire logic                         cc_flip_in,
	input  wire logic [1:0]                   cc_partner_current_in,
	input  wire typec_pkg::current_level_type adv_current_sel_in,
	input  wire typec_pkg::port_role_type     role_sel_in,
	input  wire logic                         reg_change_in,
	input  wire logic                         irq_ack_in,
	output logic                              current_level_out_a_o_out,
	output logic                              current_level_out_a_oe_out,
	output logic                              current_level_out_b_o_out,
	output logic                              current_level_out_b_oe_out,
	output logic                              change_irq_n_o_out,
	output logic                              change_irq_n_oe_out,
	output logic                              attach_indicator_n_o_out,
	output logic                              attach_indicator_n_oe_out,
	output typec_pkg::current_level_type      cc_adv_current_out,
	output logic                              mux_flip_out,
	output logic                              acting_host_out,
	output logic                              serial_mode_out,
	output logic                              bus_addr_bit6_out,
	output logic                              low_power_out
);
	import typec_pkg::*;

	strap_if straps ();

	strap_decode u_strap (
		.clk_in             (clk_in),
		.reset_in           (reset_in),
		.port_strap_high_in (port_strap_high_in),
		.port_strap_low_in  (port_strap_low_in),
		.addr_strap_high_in (addr_strap_high_in),
		.addr_strap_low_in  (addr_strap_low_in),
		.straps             (straps.provider)
	);

	logic [`SYNC_W-1:0] sync1_reg;
	logic [`SYNC_W-1:0] sync2_reg;
	attach_state_type   state_reg;
	attach_state_type   state_next;
	logic               enabled;
	logic               serial;
	port_role_type      role;
	current_level_type  partner_cur;
	logic               enabled_reg;
	logic               irq_reg;
	logic               irq_next;
	logic               flip_reg;
	logic               flip_next;
	logic               cur_a_oe_next;
	logic               cur_b_oe_next;
	logic               irq_oe_reg;
	logic               irq_oe_next;
	logic               att_oe_reg;
	logic               att_oe_next;
	logic               cur_a_oe_reg;
	logic               cur_b_oe_reg;
	current_level_type  adv_reg;
	current_level_type  adv_next;

	// ------------------------------------------------------------
	// Decode of synchronised pins and straps
	// ------------------------------------------------------------
	always_comb begin
		enabled     = !sync2_reg[`SYNC_ENN_BIT] && straps.valid;
		serial      = (straps.ctrl_mode == MODE_SERIAL);
		role        = serial ? role_sel_in : straps.port_role;
		partner_cur = current_level_type'(sync2_reg[`SYNC_CUR_MSB:`SYNC_CUR_LSB]);
	end

	// ------------------------------------------------------------
	// Attach state machine
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		flip_next  = flip_reg;
		if (!enabled) begin
			state_next = ST_DETACHED;
		end else begin
			case (state_reg)
				ST_DETACHED: begin
					if (sync2_reg[`SYNC_AUDIO_BIT]) begin
						state_next = ST_AUDIO;
					end else if (sync2_reg[`SYNC_SOURCE_BIT] && role != ROLE_SOURCE) begin
						// Dual role checks sink first, giving try-sink preference
						state_next = ST_ATT_SINK;
					end else if (sync2_reg[`SYNC_SINK_BIT] && role != ROLE_SINK) begin
						state_next = ST_ATT_HOST;
					end
					// Orientation is frozen at attach so the mux never moves mid-link
					if (sync2_reg[`SYNC_AUDIO_BIT] || sync2_reg[`SYNC_SOURCE_BIT]
						|| sync2_reg[`SYNC_SINK_BIT]) begin
						flip_next = sync2_reg[`SYNC_FLIP_BIT];
					end
				end
				ST_ATT_HOST: begin
					if (!sync2_reg[`SYNC_SINK_BIT]) begin
						state_next = ST_DETACHED;
					end
				end
				ST_ATT_SINK: begin
					if (!sync2_reg[`SYNC_SOURCE_BIT]) begin
						state_next = ST_DETACHED;
					end
				end
				ST_AUDIO: begin
					if (!sync2_reg[`SYNC_AUDIO_BIT]) begin
						state_next = ST_DETACHED;
					end
				end
				default: state_next = ST_DETACHED;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Status pins, interrupt latch, advertised current
	// ------------------------------------------------------------
	always_comb begin
		irq_next = 1'b0;
		if (serial) begin
			// Set wins over acknowledge in the same cycle
			irq_next = (irq_reg && !irq_ack_in) || reg_change_in
				|| (state_next != state_reg);
		end
		cur_a_oe_next = 1'b0;
		cur_b_oe_next = 1'b0;
		if (enabled && !serial && state_next == ST_ATT_SINK) begin
			cur_a_oe_next = (partner_cur == CUR_MEDIUM) || (partner_cur == CUR_HIGH);
			cur_b_oe_next = (partner_cur == CUR_HIGH);
		end
		if (!enabled) begin
			irq_oe_next = 1'b0;
		end else if (serial) begin
			irq_oe_next = irq_next;
		end else begin
			irq_oe_next = (state_next == ST_AUDIO);
		end
		att_oe_next = enabled && (state_next == ST_ATT_HOST);
		adv_next    = serial ? adv_current_sel_in : CUR_DEFAULT;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			sync1_reg    <= `SYNC_RESET;
			sync2_reg    <= `SYNC_RESET;
			state_reg    <= ST_DETACHED;
			enabled_reg  <= 1'b0;
			irq_reg      <= 1'b0;
			flip_reg     <= 1'b0;
			cur_a_oe_reg <= 1'b0;
			cur_b_oe_reg <= 1'b0;
			irq_oe_reg   <= 1'b0;
			att_oe_reg   <= 1'b0;
			adv_reg      <= CUR_DEFAULT;
		end else begin
			sync1_reg    <= {chip_enable_n_in, cc_partner_current_in, cc_flip_in,
				cc_audio_seen_in, cc_source_seen_in, cc_sink_seen_in};
			sync2_reg    <= sync1_reg;
			state_reg    <= state_next;
			enabled_reg  <= enabled;
			irq_reg      <= irq_next;
			flip_reg     <= flip_next;
			cur_a_oe_reg <= cur_a_oe_next;
			cur_b_oe_reg <= cur_b_oe_next;
			irq_oe_reg   <= irq_oe_next;
			att_oe_reg   <= att_oe_next;
			adv_reg      <= adv_next;
		end
	end

	assign current_level_out_a_o_out  = 1'b0;
	assign current_level_out_b_o_out  = 1'b0;
	assign change_irq_n_o_out         = 1'b0;
	assign attach_indicator_n_o_out   = 1'b0;
	assign current_level_out_a_oe_out = cur_a_oe_reg;
	assign current_level_out_b_oe_out = cur_b_oe_reg;
	assign change_irq_n_oe_out        = irq_oe_reg;
	assign attach_indicator_n_oe_out  = att_oe_reg;
	assign cc_adv_current_out         = adv_reg;
	assign mux_flip_out               = flip_reg;
	assign acting_host_out            = (state_reg == ST_ATT_HOST);
	assign serial_mode_out            = serial;
	assign bus_addr_bit6_out          = straps.addr_bit6;
	assign low_power_out              = !enabled_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	AST_SOURCE_NO_SINK: assert property (
		(straps.valid && role == ROLE_SOURCE && state_reg == ST_DETACHED)
		|=> state_reg != ST_ATT_SINK)
		else $error("source role attached as sink");
	AST_TRY_SINK: assert property (
		(enabled && state_reg == ST_DETACHED && role == ROLE_DUAL_TRY_SINK
		&& sync2_reg[`SYNC_SOURCE_BIT] && sync2_reg[`SYNC_SINK_BIT]
		&& !sync2_reg[`SYNC_AUDIO_BIT]) |=> state_reg == ST_ATT_SINK)
		else $error("dual role did not prefer sink");
	AST_CUR_HIGH: assert property (
		(enabled && !serial && state_next == ST_ATT_SINK && partner_cur == CUR_HIGH)
		|=> current_level_out_a_oe_out && current_level_out_b_oe_out)
		else $error("high current not reported");
	AST_IRQ_SET: assert property (
		(enabled && serial && reg_change_in) |=> change_irq_n_oe_out)
		else $error("interrupt missed register change");
	AST_IRQ_STICKY: assert property (
		(serial && enabled && change_irq_n_oe_out && !irq_ack_in) ##1 enabled
		|-> change_irq_n_oe_out)
		else $error("interrupt dropped without acknowledge");
	AST_AUDIO_PIN: assert property (
		(enabled_reg && !serial && state_reg == ST_AUDIO) |-> change_irq_n_oe_out)
		else $error("audio adapter not flagged");
	AST_ATTACH_IND: assert property (
		$rose(state_reg == ST_ATT_HOST) |-> attach_indicator_n_oe_out && acting_host_out)
		else $error("attach indicator not driven");
	AST_DISABLED: assert property (
		$rose(sync2_reg[`SYNC_ENN_BIT]) |=> low_power_out && !attach_indicator_n_oe_out
		&& !change_irq_n_oe_out && !current_level_out_a_oe_out && !current_level_out_b_oe_out)
		else $error("disabled device still drives pins");
	AST_PIN_DEFAULT: assert property (
		(straps.valid && !serial) |=> cc_adv_current_out == CUR_DEFAULT)
		else $error("pin mode not default current");
	AST_FLIP_HOLD: assert property (
		(state_reg != ST_DETACHED && state_next == state_reg) |=> $stable(mux_flip_out))
		else $error("mux moved while attached");
	AST_SERIAL_SEL: assert property (
		serial |=> cc_adv_current_out == $past(adv_current_sel_in))
		else $error("serial current selection not applied");

	COV_HOST: cover property ($rose(attach_indicator_n_oe_out));
	COV_SINK_HIGH: cover property (current_level_out_b_oe_out);
	COV_AUDIO: cover property (!serial && change_irq_n_oe_out);
	COV_IRQ_ACK: cover property (serial && change_irq_n_oe_out ##1 !change_irq_n_oe_out);
endmodule

// ---- rtl/typec_regs.svh ----
// Constants for the Type-C port role and pin control block.
// Assumes inclusion by bare name from the rtl/ folder.
`ifndef TYPEC_REGS_SVH
`define TYPEC_REGS_SVH

// ------------------------------------------------------------
// Strap capture timing
// ------------------------------------------------------------
`define STRAP_SETTLE_CYCLES 4'h4

// ------------------------------------------------------------
// Field positions inside the synchronised pin vector
// ------------------------------------------------------------
`define SYNC_W          7
`define SYNC_SINK_BIT   0
`define SYNC_SOURCE_BIT 1
`define SYNC_AUDIO_BIT  2
`define SYNC_FLIP_BIT   3
`define SYNC_CUR_LSB    4
`define SYNC_CUR_MSB    5
`define SYNC_ENN_BIT    6

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SYNC_RESET      7'h40
`define STRAP_SYNC_RST  4'h0
`define SETTLE_RESET    4'h0

`endif

// ---- rtl/typec_pkg.sv ----
// Types and the three-level strap decode shared by the port control block.
// Assumes no surrounding context.
package typec_pkg;

	typedef enum logic [1:0] {TRI_FLOAT, TRI_HIGH, TRI_LOW} tri_level_type;
	typedef enum logic {MODE_PIN, MODE_SERIAL} control_mode_type;
	typedef enum logic [1:0] {ROLE_DUAL_TRY_SINK, ROLE_SOURCE, ROLE_SINK} port_role_type;
	typedef enum logic [1:0] {CUR_DEFAULT, CUR_MEDIUM, CUR_HIGH} current_level_type;
	typedef enum logic [1:0] {ST_DETACHED, ST_ATT_HOST, ST_ATT_SINK, ST_AUDIO} attach_state_type;

	// Both senses active is treated as floating: no firm tie seen
	function automatic tri_level_type decode_tri(input logic high, input logic low);
		if (high && !low) begin
			return TRI_HIGH;
		end else if (low && !high) begin
			return TRI_LOW;
		end
		return TRI_FLOAT;
	endfunction

endpackage

// ---- rtl/strap_if.sv ----
// Decoded strap settings passed from the strap sampler to the controller.
// Assumes one clock domain on both sides.
`timescale 1ns/1ps
interface strap_if;
	typec_pkg::control_mode_type ctrl_mode;
	logic                        addr_bit6;
	typec_pkg::port_role_type    port_role;
	logic                        valid;

	modport provider (output ctrl_mode, output addr_bit6, output port_role, output valid);
	modport consumer (input ctrl_mode, input addr_bit6, input port_role, input valid);
endinterface

// ---- rtl/strap_decode.sv ----
// Samples the address and port role straps once after reset.
// Assumes strap senses are asynchronous comparator levels.
`timescale 1ns/1ps
`include "typec_regs.svh"
module strap_decode (
	input  wire logic clk_in,
	input  wire logic reset_in,
	input  wire logic port_strap_high_in,
	input  wire logic port_strap_low_in,
	input  wire logic addr_strap_high_in,
	input  wire logic addr_strap_low_in,
	strap_if.provider straps
);
	import typec_pkg::*;

	logic [3:0]       sync1_reg;
	logic [3:0]       sync2_reg;
	logic [3:0]       settle_reg;
	logic [3:0]       settle_next;
	logic             valid_reg;
	logic             valid_next;
	control_mode_type mode_reg;
	control_mode_type mode_next;
	logic             bit6_reg;
	logic             bit6_next;
	port_role_type    role_reg;
	port_role_type    role_next;
	tri_level_type    addr_lvl;
	tri_level_type    port_lvl;

	// ------------------------------------------------------------
	// Capture once; later strap motion is ignored until reset
	// ------------------------------------------------------------
	always_comb begin
		addr_lvl    = decode_tri(sync2_reg[3], sync2_reg[2]);
		port_lvl    = decode_tri(sync2_reg[1], sync2_reg[0]);
		settle_next = settle_reg;
		valid_next  = valid_reg;
		mode_next   = mode_reg;
		bit6_next   = bit6_reg;
		role_next   = role_reg;
		if (!valid_reg) begin
			if (settle_reg == `STRAP_SETTLE_CYCLES) begin
				valid_next = 1'b1;
				mode_next  = (addr_lvl == TRI_FLOAT) ? MODE_PIN : MODE_SERIAL;
				bit6_next  = (addr_lvl == TRI_HIGH);
				case (port_lvl)
					TRI_HIGH: role_next = ROLE_SOURCE;
					TRI_LOW:  role_next = ROLE_SINK;
					default:  role_next = ROLE_DUAL_TRY_SINK;
				endcase
			end else begin
				settle_next = settle_reg + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			sync1_reg  <= `STRAP_SYNC_RST;
			sync2_reg  <= `STRAP_SYNC_RST;
			settle_reg <= `SETTLE_RESET;
			valid_reg  <= 1'b0;
			mode_reg   <= MODE_PIN;
			bit6_reg   <= 1'b0;
			role_reg   <= ROLE_DUAL_TRY_SINK;
		end else begin
			sync1_reg  <= {addr_strap_high_in, addr_strap_low_in,
				port_strap_high_in, port_strap_low_in};
			sync2_reg  <= sync1_reg;
			settle_reg <= settle_next;
			valid_reg  <= valid_next;
			mode_reg   <= mode_next;
			bit6_reg   <= bit6_next;
			role_reg   <= role_next;
		end
	end

	assign straps.valid     = valid_reg;
	assign straps.ctrl_mode = mode_reg;
	assign straps.addr_bit6 = bit6_reg;
	assign straps.port_role = role_reg;

	AST_STRAP_HOLD: assert property (@(posedge clk_in) disable iff (reset_in)
		valid_reg |=> valid_reg && $stable(mode_reg) && $stable(role_reg))
		else $error("strap setting moved after capture");
endmodule

// ---- tb/pin_partner_model.sv ----
// Host board side strap and enable pin model for the port control block.
// Assumes the bench changes its requests just after a falling edge.
`timescale 1ns/1ps
module pin_partner_model (
	input  wire logic [1:0] port_strap_in,
	input  wire logic [1:0] addr_strap_in,
	input  wire logic       enable_drive_in,
	output logic            port_strap_high_out,
	output logic            port_strap_low_out,
	output logic            addr_strap_high_out,
	output logic            addr_strap_low_out,
	output logic            chip_enable_n_out
);
	// ------------------------------------------------------------
	// Three-level straps: 0 floating, 1 tied high, 2 tied low
	// ------------------------------------------------------------
	assign port_strap_high_out = (port_strap_in == 2'h1);
	assign port_strap_low_out  = (port_strap_in == 2'h2);
	assign addr_strap_high_out = (addr_strap_in == 2'h1);
	assign addr_strap_low_out  = (addr_strap_in == 2'h2);

	// ------------------------------------------------------------
	// Enable pin
	// ------------------------------------------------------------
	// Released pin falls to the weak pull-up, so the part is disabled
	assign chip_enable_n_out = enable_drive_in ? 1'b0 : 1'b1;
endmodule

// ---- tb/test_typec_port_control.sv ----
// Self-checking bench for the port control block against a pin-level model.
// Assumes the design and its package are compiled first.
`timescale 1ns/1ps
module test_typec_port_control;
	import typec_pkg::*;
	logic                clk_in, reset_in, en_drv, cc_sink, cc_src, cc_audio, cc_flip;
	logic [1:0]          port_code, addr_code, cc_cur;
	logic                psh, psl, ash, asl, enn, reg_change, irq_ack;
	current_level_type   adv_sel, adv_out;
	port_role_type       role_sel;
	logic                a_oe, b_oe, irq_oe, att_oe, mux, host, ser, bit6, lowp;
	logic [3:0]          od_lo;
	int                  fails, checks_done;
	logic [15:0]         lfsr;

	pin_partner_model pin_partner_model_i (.port_strap_in(port_code), .addr_strap_in(addr_code),
		.enable_drive_in(en_drv), .port_strap_high_out(psh), .port_strap_low_out(psl),
		.addr_strap_high_out(ash), .addr_strap_low_out(asl), .chip_enable_n_out(enn));

	typec_port_control typec_port_control_i (.clk_in(clk_in), .reset_in(reset_in),
		.chip_enable_n_in(enn), .port_strap_high_in(psh), .port_strap_low_in(psl),
		.addr_strap_high_in(ash), .addr_strap_low_in(asl), .cc_sink_seen_in(cc_sink),
		.cc_source_seen_in(cc_src), .cc_audio_seen_in(cc_audio), .cc_flip_in(cc_flip),
		.cc_partner_current_in(cc_cur), .adv_current_sel_in(adv_sel), .role_sel_in(role_sel),
		.reg_change_in(reg_change), .irq_ack_in(irq_ack),
		.current_level_out_a_o_out(od_lo[0]), .current_level_out_a_oe_out(a_oe),
		.current_level_out_b_o_out(od_lo[1]), .current_level_out_b_oe_out(b_oe),
		.change_irq_n_o_out(od_lo[2]), .change_irq_n_oe_out(irq_oe),
		.attach_indicator_n_o_out(od_lo[3]), .attach_indicator_n_oe_out(att_oe),
		.cc_adv_current_out(adv_out), .mux_flip_out(mux), .acting_host_out(host),
		.serial_mode_out(ser), .bus_addr_bit6_out(bit6), .low_power_out(lowp));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] lfsr_step(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// Expected {attach, irq, level b, level a} pulls in pin mode
	function automatic logic [3:0] exp_pins(input int role, input logic s, input logic src,
		input logic au, input logic [1:0] cur, input logic en);
		logic hst;
		logic snk;
		hst = 1'b0;
		snk = 1'b0;
		if (!en || au) begin
			return {1'b0, en & au, 2'b00};
		end
		if (role == 1) begin
			hst = s;
		end else if (role == 2) begin
			snk = src;
		end else begin
			snk = src;
			hst = s & !src;
		end
		return {hst, 1'b0, snk & (cur == 2'h2), snk & (cur != 2'h0)};
	endfunction

	task automatic summarize();
		if (fails == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask

	task automatic do_reset(input logic [1:0] pc, input logic [1:0] ac);
		port_code = pc;
		addr_code = ac;
		reset_in  = 1'b1;
		repeat (4) @(negedge clk_in);
		reset_in = 1'b0;
		repeat (10) @(negedge clk_in);
	endtask

	task automatic set_cc(input logic s, input logic src, input logic au, input logic f,
		input logic [1:0] cur);
		cc_sink  = s;
		cc_src   = src;
		cc_audio = au;
		cc_flip  = f;
		cc_cur   = cur;
		repeat (6) @(negedge clk_in);
	endtask

	task automatic cmp_pins(input int role);
		check(8'({att_oe, irq_oe, b_oe, a_oe}), 8'(exp_pins(role, cc_sink, cc_src, cc_audio,
			cc_cur, en_drv)));
		// Open-drain pins only ever pull low
		check(8'(od_lo), 8'h00);
	endtask

	task automatic pulse(input logic chg, input logic ack);
		reg_change = chg;
		irq_ack    = ack;
		@(negedge clk_in);
		reg_change = 1'b0;
		irq_ack    = 1'b0;
		@(negedge clk_in);
	endtask

	// ------------------------------------------------------------
	// Clock, watchdog, main sequence
	// ------------------------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	// Whole run needs about 940 cycles; allow well over twice that
	initial begin
		#100000;
		fails++;
		summarize();
	end

	initial begin
		fails = 0;
		checks_done = 0;
		lfsr = 16'h0017;
		en_drv = 1'b1;
		{cc_sink, cc_src, cc_audio, cc_flip, cc_cur, reg_change, irq_ack} = 8'h00;
		adv_sel = CUR_DEFAULT;
		role_sel = ROLE_DUAL_TRY_SINK;
		port_code = 2'h0;
		addr_code = 2'h0;
		reset_in = 1'b1;
		// Pin control: role codes 0 dual try-sink, 1 source, 2 sink
		for (int r = 0; r < 3; r++) begin
			do_reset(r[1:0], 2'h0);
			check(8'({ser, lowp}), 8'h00);
			for (int c = 0; c < 3; c++) begin
				set_cc(1'b0, 1'b1, 1'b0, 1'b0, c[1:0]);
				cmp_pins(r);
				set_cc(1'b1, 1'b0, 1'b0, 1'b0, c[1:0]);
				cmp_pins(r);
				check(8'(adv_out), 8'(CUR_DEFAULT));
			end
			for (int f = 0; f < 2; f++) begin
				set_cc(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
				set_cc(1'b1, 1'b1, 1'b0, f[0], 2'h0);
				check(8'(mux), 8'(f));
			end
			for (int i = 0; i < 16; i++) begin
				lfsr = lfsr_step(lfsr);
				set_cc(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
				set_cc(lfsr[0], lfsr[1], lfsr[2] & lfsr[3], lfsr[4],
					(lfsr[6:5] == 2'h3) ? 2'h2 : lfsr[6:5]);
				cmp_pins(r);
			end
			set_cc(1'b0, 1'b0, 1'b1, 1'b0, 2'h0);
			cmp_pins(r);
			en_drv = 1'b0;
			set_cc(1'b1, 1'b1, 1'b1, 1'b0, 2'h2);
			cmp_pins(r);
			check(8'(lowp), 8'h01);
			en_drv = 1'b1;
			set_cc(1'b0, 1'b1, 1'b0, 1'b0, 2'h2);
			cmp_pins(r);
		end
		// Serial control: strap high with source role, then strap low with sink role
		for (int a = 1; a < 3; a++) begin
			set_cc(1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
			role_sel = (a == 1) ? ROLE_SOURCE : ROLE_SINK;
			do_reset(2'h0, a[1:0]);
			check(8'({ser, bit6}), {6'h00, 1'b1, a == 1});
			for (int k = 0; k < 3; k++) begin
				adv_sel = current_level_type'(k);
				repeat (2) @(negedge clk_in);
				check(8'(adv_out), 8'(k));
			end
			pulse(1'b0, 1'b1);
			check(8'(irq_oe), 8'h00);
			pulse(1'b1, 1'b0);
			check(8'(irq_oe), 8'h01);
			pulse(1'b0, 1'b1);
			check(8'(irq_oe), 8'h00);
			pulse(1'b1, 1'b1);
			check(8'(irq_oe), 8'h01);
			pulse(1'b0, 1'b1);
			// Current pins are bus pins in serial mode, so stay released as sink
			set_cc(a == 1, a == 2, 1'b0, 1'b1, 2'h2);
			check(8'({att_oe, irq_oe, b_oe, a_oe, host}), (a == 1) ? 8'h19 : 8'h08);
			check(8'(mux), 8'h01);
			pulse(1'b0, 1'b1);
		end
		summarize();
	end
endmodule
